// ==== logic/rsb_irq_status.sv ====
/*
  Channel B half (bits 7 to 4) of the receive interrupt status register,
  together with the channel B receive data register it watches.
  Assumes the receiver, the bit-time enable and the serial register
  interface are all logic on the device clock, so nothing is synchronised.
  The end-of-frame bit count comes from the configuration register kept
  elsewhere. The low nibble belongs to channel A and reads as zero here.
*/
`timescale 1ns/1ps
`include "rsb_regs.svh"

module rsb_irq_status #(
  parameter int DATA_W = 8,
  parameter int CNT_W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input rsb_pkg::rsb_rx_evt_t i_rx,
  input wire logic i_rx_active,
  input wire logic i_bit_tick,
  input wire logic i_bit_valid,
  input wire logic [CNT_W-1:0] i_eof_bits,
  input rsb_pkg::rsb_rd_req_t i_rd,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_rd_hit,
  output logic [7:0] o_status
);

  import rsb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  wire logic rd_status = i_rd.strobe & (i_rd.addr == `RSB_ADDR_STATUS);
  wire logic rd_data_b = i_rd.strobe & (i_rd.addr == `RSB_ADDR_DATA_B);
  wire logic rd_mapped = rd_status | rd_data_b;

  ////////////////////////////////////////////////////////////////////////
  // Receive data B register

  logic [DATA_W-1:0] byte_q;
  logic byte_fresh;

  rsb_byte_reg #(
    .DATA_W(DATA_W)
  ) u_data_b (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_load(i_rx.load),
    .i_data(i_rx.data[DATA_W-1:0]),
    .i_take(rd_data_b),
    .o_data(byte_q),
    .o_fresh(byte_fresh)
  );

  ////////////////////////////////////////////////////////////////////////
  // Flow violation events

  // New byte lands over one the host has not yet taken
  wire logic overflow = i_rx.load & byte_fresh & ~rd_data_b;
  // Host reads the data register with nothing new in it
  wire logic underflow = rd_data_b & ~byte_fresh;
  wire logic flow_evt = overflow | underflow;

  ////////////////////////////////////////////////////////////////////////
  // End-of-frame watch

  rsb_eof_t eof_state_reg;
  rsb_eof_t eof_state_next;
  logic [CNT_W-1:0] silent_cnt_reg;
  logic [CNT_W-1:0] silent_cnt_next;

  wire logic eof_enabled = (i_eof_bits != CNT_W'(`RSB_CNT_ZERO));
  wire logic silent_tick = i_bit_tick & ~i_bit_valid;
  wire logic [CNT_W-1:0] silent_inc = silent_cnt_reg + CNT_W'(`RSB_CNT_ONE);
  wire logic count_done = eof_enabled & (silent_inc == i_eof_bits);
  // No report once reception has stopped, even on the tick that ends it
  wire logic eof_evt = i_rx_active & (eof_state_reg == RSB_EOF_COUNT) &
                       silent_tick & count_done;

  always_comb begin
    eof_state_next = eof_state_reg;
    silent_cnt_next = silent_cnt_reg;
    unique case (eof_state_reg)
      RSB_EOF_IDLE: begin
        silent_cnt_next = CNT_W'(`RSB_CNT_ZERO);
        if (i_rx_active) begin
          eof_state_next = RSB_EOF_COUNT;
        end
      end
      RSB_EOF_COUNT: begin
        if (!i_rx_active) begin
          eof_state_next = RSB_EOF_IDLE;
          silent_cnt_next = CNT_W'(`RSB_CNT_ZERO);
        end else if (i_bit_tick && i_bit_valid) begin
          silent_cnt_next = CNT_W'(`RSB_CNT_ZERO);
        end else if (eof_evt) begin
          eof_state_next = RSB_EOF_HIT;
          silent_cnt_next = CNT_W'(`RSB_CNT_ZERO);
        end else if (silent_tick) begin
          silent_cnt_next = silent_inc;
        end
      end
      RSB_EOF_HIT: begin
        // One report per silence; a valid bit rearms the watch
        silent_cnt_next = CNT_W'(`RSB_CNT_ZERO);
        if (!i_rx_active) begin
          eof_state_next = RSB_EOF_IDLE;
        end else if (i_bit_tick && i_bit_valid) begin
          eof_state_next = RSB_EOF_COUNT;
        end
      end
      default: begin
        eof_state_next = RSB_EOF_IDLE;
        silent_cnt_next = CNT_W'(`RSB_CNT_ZERO);
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      eof_state_reg <= RSB_EOF_IDLE;
      silent_cnt_reg <= CNT_W'(`RSB_CNT_ZERO);
    end else begin
      eof_state_reg <= eof_state_next;
      silent_cnt_reg <= silent_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status flags

  logic valid_reg;
  logic flow_reg;
  logic eof_reg;
  logic full_reg;

  // Pending flags clear on a status read; a new event in that cycle wins
  wire logic clr = rd_status;

  // Tracks the byte currently held, not sticky
  wire logic valid_next = i_rx.load ? i_rx.all_valid : valid_reg;
  wire logic flow_next = flow_evt | (flow_reg & ~clr);
  wire logic eof_next = eof_evt | (eof_reg & ~clr);
  wire logic full_next = i_rx.load | (full_reg & ~clr);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      valid_reg <= `RSB_STATUS_RST;
      flow_reg <= `RSB_STATUS_RST;
      eof_reg <= `RSB_STATUS_RST;
      full_reg <= `RSB_STATUS_RST;
    end else begin
      valid_reg <= valid_next;
      flow_reg <= flow_next;
      eof_reg <= eof_next;
      full_reg <= full_next;
    end
  end

  wire logic [7:0] status_word = {valid_reg, flow_reg, eof_reg, full_reg, `RSB_LOW_NIBBLE};

  assign o_status = status_word;

  ////////////////////////////////////////////////////////////////////////
  // Read port

  // Unmapped addresses answer zero with the hit flag low
  wire logic [DATA_W-1:0] rd_mux = rd_status ? DATA_W'(status_word) :
                                   rd_data_b ? byte_q :
                                   DATA_W'(`RSB_DATA_RST);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rd_data <= DATA_W'(`RSB_DATA_RST);
      o_rd_hit <= 1'b0;
    end else begin
      o_rd_hit <= i_rd.strobe & rd_mapped;
      if (i_rd.strobe) begin
        o_rd_data <= rd_mux;
      end
    end
  end

endmodule : rsb_irq_status

// ==== common/rsb_regs.svh ====
/*
  Register addresses, field positions and reset values of the channel B
  receive status logic.
  Assumes the serial interface presents 6-bit register addresses.
*/
`ifndef RSB_REGS_SVH
`define RSB_REGS_SVH

// Register addresses
`define RSB_ADDR_W 6
`define RSB_ADDR_EOF_CFG 6'h06
`define RSB_ADDR_DATA_B 6'h0B
`define RSB_ADDR_STATUS 6'h08

// Status fields, upper nibble only
`define RSB_BIT_VALID_B 7
`define RSB_BIT_FLOW_B 6
`define RSB_BIT_EOF_B 5
`define RSB_BIT_FULL_B 4
`define RSB_LOW_NIBBLE 4'h0

// Reset values and counter constants
`define RSB_STATUS_RST 1'b0
`define RSB_DATA_RST 8'h00
`define RSB_CNT_ONE 8'h01
`define RSB_CNT_ZERO 8'h00

`endif

// ==== common/rsb_pkg.sv ====
/*
  Types shared by the channel B receive status logic.
  Assumes the receiver and the serial interface run on the device clock.
*/
package rsb_pkg;

  // One byte handed over by the channel B receiver
  typedef struct packed {
    logic load;
    logic all_valid;
    logic [7:0] data;
  } rsb_rx_evt_t;

  // One register read from the serial interface
  typedef struct packed {
    logic strobe;
    logic [5:0] addr;
  } rsb_rd_req_t;

  // End-of-frame watch, Gray coded along idle, count, expired
  typedef enum logic [1:0] {
    RSB_EOF_IDLE = 2'b00,
    RSB_EOF_COUNT = 2'b01,
    RSB_EOF_HIT = 2'b11
  } rsb_eof_t;

endpackage : rsb_pkg

// ==== logic/rsb_byte_reg.sv ====
/*
  Channel B receive data holding register with a fresh-data flag.
  Assumes load and take are one-cycle pulses on the device clock.
*/
`timescale 1ns/1ps
`include "rsb_regs.svh"

module rsb_byte_reg #(
  parameter int DATA_W = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_load,
  input wire logic [DATA_W-1:0] i_data,
  input wire logic i_take,
  output logic [DATA_W-1:0] o_data,
  output logic o_fresh
);

  // A load in the same cycle as a take leaves the new byte fresh
  wire logic fresh_next = i_load | (o_fresh & ~i_take);

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_data <= DATA_W'(`RSB_DATA_RST);
      o_fresh <= 1'b0;
    end else begin
      if (i_load) begin
        o_data <= i_data;
      end
      o_fresh <= fresh_next;
    end
  end

endmodule : rsb_byte_reg

// ==== sim/rsb_chk.sv ====
/* Checker on the ports of the channel B status block.
   Assumes one clock domain and an active-low asynchronous reset. */
`timescale 1ns/1ps
module rsb_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input rsb_pkg::rsb_rx_evt_t i_rx,
  input wire logic i_rx_active,
  input wire logic i_bit_tick,
  input wire logic i_bit_valid,
  input rsb_pkg::rsb_rd_req_t i_rd,
  input wire logic [7:0] o_status
);
  import rsb_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // Data B read with no byte arriving in the same cycle
  wire logic rd_b = i_rd.strobe && i_rd.addr == 6'h0B && !i_rx.load;
  a_valid_load: assert property (i_rx.load |=> o_status[7] == $past(i_rx.all_valid))
    else $error("valid flag does not follow loaded byte");
  a_valid_held: assert property (!i_rx.load |=> $stable(o_status[7]))
    else $error("valid flag changed without a load");
  a_under_flow: assert property (rd_b ##1 rd_b |=> o_status[6])
    else $error("underflow not flagged");
  a_eof_cause: assert property ($rose(o_status[5]) |-> $past(i_rx_active && i_bit_tick && !i_bit_valid))
    else $error("end of frame flag without silent tick");
  a_full_load: assert property (i_rx.load |=> o_status[4])
    else $error("full flag not set on load");
endmodule : rsb_chk

bind rsb_irq_status rsb_chk u_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_rx(i_rx),
  .i_rx_active(i_rx_active), .i_bit_tick(i_bit_tick), .i_bit_valid(i_bit_valid),
  .i_rd(i_rd), .o_status(o_status));

// ==== sim/rsb_host.sv ====
/* Host model issuing random register reads, mapped and unmapped.
   Assumes the device clock and reset of the bench. */
`timescale 1ns/1ps
module rsb_host (
  input wire logic i_clk,
  input wire logic i_nrst,
  output rsb_pkg::rsb_rd_req_t o_rd
);
  import rsb_pkg::*;
  int seed = 19867;
  int r;
  initial o_rd = '0;
  always @(posedge i_clk) begin
    #1;
    r = $random(seed);
    o_rd.strobe = i_nrst && r[1:0] == 2'h0;
    o_rd.addr = r[3:2] == 2'h3 ? 6'h3F : r[2] ? 6'h0B : 6'h08;
  end
endmodule : rsb_host

// ==== sim/tb_top.sv ====
/* Bench for the channel B status block: random receiver and bit-time
   stimulus against a reference model checked every cycle.
   Assumes the host model makes all register reads. */
`timescale 1ns/1ps
module tb_top;
  import rsb_pkg::*;
  logic clk, nrst, act, tk, bv, hit;
  logic [7:0] nbits, rd_data, status;
  rsb_rx_evt_t rx;
  rsb_rd_req_t rd;
  int seed = 19867;
  int fail_count, cmp_count, r, cnt, es, st, v, fl, eo, fu, fr, byt, erd, ehit;
  rsb_irq_status i_dut (.i_clk(clk), .i_nrst(nrst), .i_rx(rx), .i_rx_active(act),
    .i_bit_tick(tk), .i_bit_valid(bv), .i_eof_bits(nbits), .i_rd(rd),
    .o_rd_data(rd_data), .o_rd_hit(hit), .o_status(status));
  rsb_host u_host (.i_clk(clk), .i_nrst(nrst), .o_rd(rd));
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input int exp);
    cmp_count++;
    if (got !== exp[7:0]) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp[7:0]);
    end
  endtask : chk
  task automatic finish_test;
    $display("cmp_count=%0d fail_count=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////
  // Compare then advance the model with the inputs of the coming edge
  always @(negedge clk) if (nrst) begin
    chk({7'h00, status[7]}, v);
    chk({7'h00, status[6]}, fl);
    chk({7'h00, status[5]}, eo);
    chk({3'h0, status[4:0]}, fu << 4);
    chk(rd_data, erd);
    chk({7'h00, hit}, ehit);
    st = v << 7 | fl << 6 | eo << 5 | fu << 4;
    ehit = rd.strobe && (rd.addr == 6'h08 || rd.addr == 6'h0B);
    if (rd.strobe) erd = rd.addr == 6'h08 ? st : rd.addr == 6'h0B ? byt : 0;
    if (rd.strobe && rd.addr == 6'h08) {fl, eo, fu} = '0;
    if (rd.strobe && rd.addr == 6'h0B && !fr) fl = 1;
    if (rx.load) begin
      if (fr && !(rd.strobe && rd.addr == 6'h0B)) fl = 1;
      v = rx.all_valid;
      fu = 1;
      byt = rx.data;
      fr = 1;
    end else if (rd.strobe && rd.addr == 6'h0B) fr = 0;
    if (!act) begin
      es = 0;
      cnt = 0;
    end else if (es == 0) es = 1;
    else if (tk && bv) begin
      es = 1;
      cnt = 0;
    end else if (tk && es == 1) begin
      cnt++;
      if (cnt == nbits && nbits != 0) begin
        eo = 1;
        es = 2;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    nrst = 0;
    act = 0;
    tk = 0;
    bv = 0;
    nbits = 0;
    rx = '0;
    repeat (8) @(posedge clk);
    #1 nrst = 1;
    // Bit counts 0 (disabled) to 3, changed only while idle
    for (int n = 0; n < 4; n++) begin
      nbits = n[7:0];
      repeat (2) @(posedge clk);
      #1 act = 1;
      repeat (2) @(posedge clk);
      repeat (2000) begin
        #1 r = $random(seed);
        rx = {r[2:0] == 3'h0, r[3], r[11:4]};
        tk = r[13:12] == 2'h0;
        bv = r[15:14] == 2'h0;
        @(posedge clk);
      end
      #1 rx = '0;
      tk = 0;
      act = 0;
    end
    finish_test;
  end
  // About 8,000 cycles are needed; twelve times that cuts a hang
  initial begin
    #500000;
    fail_count++;
    finish_test;
  end
endmodule : tb_top
